//--- core/saos_exec.v
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "saos_defs.vh"

// Notes on behaviour
// RQ1 - Set-all-ones writes FFh into the addressed data register.
// RQ2 - Bank bit 0 addresses the access bank, ignoring the bank select reg.
// RQ3 - Bank bit 1 forms the address from the bank select register.
// RQ4 - Sleep clears the power-down flag.
// RQ5 - Sleep sets the timeout flag.
// RQ6 - Sleep clears the watchdog counter and its postscaler.
// RQ7 - In the last phase of sleep the core halts its oscillator.
// RQ8 - A watchdog wake-up from sleep clears the timeout flag.
// RQ9 - Rotate right without carry; bit 0 to bit 7; d=0 targets W.
// RQ10 - Set-all-ones takes one cycle and leaves arithmetic flags alone.
module saos_exec (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire [15:0] instr_word,
  input  wire        instr_valid,
  output wire        instr_ready,
  output reg  [11:0] mem_raddr_r,
  input  wire [7:0]  mem_rdata,
  output reg  [11:0] mem_waddr_r,
  output reg  [7:0]  mem_wdata_r,
  output reg         mem_we_r,
  input  wire        wake_pin,
  output wire        osc_run,
  output wire        sleeping,
  output wire        timeout_flag,
  output wire        powerdown_flag,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_r,
  output wire        irq
);

  localparam [1:0]  ST_AWAKE = 2'b01;
  localparam [1:0]  ST_SLEEP = 2'b10;
  localparam integer WD_TICK_LAST_I = `SAOS_WD_TICK_CYC - 1;
  localparam [15:0]  WD_TICK_LAST   = WD_TICK_LAST_I[15:0];

  // ==========================================================
  // Address forming shared by read and write ports
  function [11:0] saos_addr;
    input [7:0] f;
    input       a;
    input [3:0] bank_sel;
    begin
      // Access bank: low half in bank 0, high half in the top bank
      if (!a) begin
        if (f < `SAOS_ACC_SPLIT)
          saos_addr = {`SAOS_ACC_LO_BANK, f};  // RQ2
        else
          saos_addr = {`SAOS_ACC_HI_BANK, f};  // RQ2
      end else begin
        // Banked access takes the upper bits from the bank select
        saos_addr = {bank_sel, f};  // RQ3
      end
    end
  endfunction

  reg  [1:0]  state_r;
  reg  [15:0] ir_r;
  reg         ir_v_r;
  reg  [7:0]  res_r;
  reg  [7:0]  ctrl_r;
  reg  [7:0]  wreg_r;
  reg  [3:0]  bank_select_reg_r;
  // Power status flags
  reg         pwrdn_r;
  reg         to_r;
  // Arithmetic flags, touched only by the rotate
  reg         neg_r;
  reg         zero_r;
  // Watchdog prescaler, counter and postscaler
  reg  [15:0] wd_pre_r;
  reg  [7:0]  watchdog_counter_r;
  reg  [7:0]  wd_post_r;
  reg  [7:0]  irq_stat_r;
  reg  [7:0]  irq_stat_nxt;
  reg  [7:0]  irq_mask_r;
  reg         wake_s1_r;
  reg         wake_s2_r;
  reg  [7:0]  ev;

  wire        q_tick;
  wire [3:0]  q_phase_r;
  wire        is_set_ones;
  wire        is_rot_nc;
  wire        is_sleep;
  wire        to_w;
  wire [11:0] op_addr;
  wire        wd_tick;
  wire        wd_wrap;
  wire        wd_timeout;
  wire        do_sleep;
  wire        wake_wd;
  wire        wake_ext;

  // ==========================================================
  // Phase sequencer
  assign osc_run = (state_r == ST_AWAKE) & ctrl_r[`SAOS_CTRL_RUN];  // RQ7

  saos_qgen u_qgen (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .osc_run   (osc_run),
    .q_tick    (q_tick),
    .q_phase_r (q_phase_r)
  );

  assign instr_ready = q_tick & q_phase_r[0];
  assign sleeping    = (state_r == ST_SLEEP);

  // ==========================================================
  // Decode
  // Only a word offered at Q1 is decoded; others act as no-ops
  assign is_set_ones = ir_v_r & (ir_r[15:9] == `SAOS_OP_SET_ONES);
  assign is_rot_nc   = ir_v_r & (ir_r[15:10] == `SAOS_OP_ROT_NC);
  assign is_sleep    = ir_v_r & (ir_r == `SAOS_OP_SLEEP);
  // Destination bit clear sends the rotate result to W
  assign to_w        = is_rot_nc & ~ir_r[9];  // RQ9
  // Sleep takes effect on the Q4 tick of its own cycle
  assign op_addr  = saos_addr(ir_r[7:0], ir_r[8], bank_select_reg_r);
  assign do_sleep = q_tick & q_phase_r[3] & is_sleep;

  // ==========================================================
  // Instruction pipeline over the four phases
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ir_r        <= 16'h0000;
      ir_v_r      <= 1'b0;
      res_r       <= 8'h00;
      mem_raddr_r <= 12'h000;
      mem_waddr_r <= 12'h000;
      mem_wdata_r <= 8'h00;
      mem_we_r    <= 1'b0;
    end else begin
      mem_we_r <= 1'b0;
      if (q_tick) begin
        if (q_phase_r[0]) begin
          ir_r   <= instr_word;
          ir_v_r <= instr_valid;
        end
        if (q_phase_r[1])
          mem_raddr_r <= op_addr;
        if (q_phase_r[2]) begin
          // Process data: fixed ones, or the rotated operand
          if (is_set_ones)
            res_r <= `SAOS_ALL_ONES;  // RQ1
          else
            res_r <= {mem_rdata[0], mem_rdata[7:1]};  // RQ9
        end
        if (q_phase_r[3]) begin
          // Write back to the data register where one is due
          if (is_set_ones || (is_rot_nc && !to_w)) begin
            mem_we_r    <= 1'b1;  // RQ1
            mem_waddr_r <= op_addr;
            mem_wdata_r <= res_r;
          end
          ir_v_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Core state and power flags
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ST_AWAKE;
      pwrdn_r <= `SAOS_PWRDN_RST;
      to_r    <= `SAOS_TMOUT_RST;
    end else begin
      case (state_r)
        ST_AWAKE: begin
          // Flags change together with sleep entry
          if (do_sleep) begin
            state_r <= ST_SLEEP;  // RQ7
            pwrdn_r <= 1'b0;  // RQ4
            to_r    <= 1'b1;  // RQ5
          end
        end
        ST_SLEEP: begin
          // A watchdog wake outranks a pin wake in the same cycle
          if (wake_wd) begin
            state_r <= ST_AWAKE;
            to_r    <= 1'b0;  // RQ8
          end else if (wake_ext) begin
            state_r <= ST_AWAKE;
          end
        end
        default: begin
          state_r <= ST_AWAKE;
        end
      endcase
    end
  end

  assign timeout_flag   = to_r;
  assign powerdown_flag = pwrdn_r;

  // ==========================================================
  // Working register and arithmetic flags
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wreg_r <= 8'h00;
      neg_r  <= 1'b0;
      zero_r <= 1'b0;
    end else begin
      // Core write to W wins over a software write in one cycle
      if (q_tick && q_phase_r[3] && is_rot_nc) begin
        neg_r  <= res_r[7];
        zero_r <= (res_r == 8'h00);
        if (to_w)
          wreg_r <= res_r;  // RQ9
      end else if (reg_wr && reg_addr == `SAOS_REG_WREG) begin
        wreg_r <= reg_wdata;
      end
      // Set-all-ones never reaches the flag update above
      // RQ10
    end
  end

  // ==========================================================
  // Watchdog with postscaler, running also during sleep
  // Prescaler turns many clocks into one slow count tick
  assign wd_tick    = ctrl_r[`SAOS_CTRL_WD_EN] &
                      (wd_pre_r == WD_TICK_LAST);
  // A wrap of the eight-bit count advances the postscaler
  assign wd_wrap    = wd_tick & (watchdog_counter_r == 8'hff);
  // Timeout on the wrap that finds the postscaler at its last step
  assign wd_timeout = wd_wrap & (wd_post_r == `SAOS_WD_POST_LAST);
  assign wake_wd    = sleeping & wd_timeout;
  assign wake_ext   = sleeping & wake_s2_r;

  // Sleep entry restarts the whole chain, so a full period
  // passes before the watchdog can wake the core
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wd_pre_r           <= 16'h0000;
      watchdog_counter_r <= `SAOS_WDT_CLR;
      wd_post_r          <= 8'h00;
    end else if (do_sleep) begin
      wd_pre_r           <= 16'h0000;
      watchdog_counter_r <= `SAOS_WDT_CLR;  // RQ6
      wd_post_r          <= 8'h00;  // RQ6
    end else if (ctrl_r[`SAOS_CTRL_WD_EN]) begin
      if (wd_tick) begin
        wd_pre_r           <= 16'h0000;
        watchdog_counter_r <= watchdog_counter_r + 8'h01;
        if (wd_timeout)
          wd_post_r <= 8'h00;
        else if (wd_wrap)
          wd_post_r <= wd_post_r + 8'h01;
      end else begin
        wd_pre_r <= wd_pre_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Wake pin synchroniser
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      wake_s1_r <= wake_pin;
      wake_s2_r <= wake_s1_r;
    end
  end

  // ==========================================================
  // Software registers
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_r            <= `SAOS_CTRL_RST;
      bank_select_reg_r <= 4'h0;
      irq_mask_r        <= `SAOS_IRQ_MASK_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `SAOS_REG_CTRL:     ctrl_r            <= reg_wdata & 8'h03;
        `SAOS_REG_BANKSEL:  bank_select_reg_r <= reg_wdata[3:0];
        `SAOS_REG_IRQ_MASK: irq_mask_r        <= reg_wdata & 8'h0f;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Interrupt status, set beats write-one-to-clear
  always @* begin
    ev = 8'h00;
    ev[`SAOS_IRQ_SLEEP]     = do_sleep;
    ev[`SAOS_IRQ_WAKE_WD]   = wake_wd;
    // Pin wake counts only when the watchdog did not win
    ev[`SAOS_IRQ_WAKE_EXT]  = wake_ext & ~wake_wd;
    ev[`SAOS_IRQ_WD_AWAKE]  = wd_timeout & ~sleeping;
    // Clear first, then set, so a new event is never lost
    irq_stat_nxt = irq_stat_r;
    if (reg_wr && reg_addr == `SAOS_REG_IRQ_STAT)
      irq_stat_nxt = irq_stat_nxt & ~reg_wdata;
    irq_stat_nxt = irq_stat_nxt | ev;
  end

  always @(posedge clk_sys) begin
    if (sys_rst)
      irq_stat_r <= 8'h00;
    else
      irq_stat_r <= irq_stat_nxt;
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ==========================================================
  // Read port, data one cycle after the strobe
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SAOS_REG_CTRL:     reg_rdata_r <= ctrl_r;
        `SAOS_REG_FLAGS:    reg_rdata_r <= {3'h0, zero_r, neg_r,
                                            sleeping, to_r, pwrdn_r};
        `SAOS_REG_WREG:     reg_rdata_r <= wreg_r;
        `SAOS_REG_BANKSEL:  reg_rdata_r <= {4'h0, bank_select_reg_r};
        `SAOS_REG_WDCNT:    reg_rdata_r <= watchdog_counter_r;
        `SAOS_REG_IRQ_STAT: reg_rdata_r <= irq_stat_r;
        `SAOS_REG_IRQ_MASK: reg_rdata_r <= irq_mask_r;
        `SAOS_REG_WDPOST:   reg_rdata_r <= wd_post_r;
        // Unmapped offsets read as zero
        default:            reg_rdata_r <= 8'h00;
      endcase
    end else begin
      // Read data stands one cycle only
      reg_rdata_r <= 8'h00;
    end
  end

endmodule // saos_exec

`default_nettype wire

//--- include/saos_defs.vh
`ifndef SAOS_DEFS_VH
`define SAOS_DEFS_VH

// ==========================================================
// Timing
`define SAOS_CLK_NS          4
`define SAOS_Q_NS            16
`define SAOS_Q_CYC           ((`SAOS_Q_NS + `SAOS_CLK_NS - 1) / `SAOS_CLK_NS)
`define SAOS_WD_TICK_NS      1000
`define SAOS_WD_TICK_CYC     (`SAOS_WD_TICK_NS / `SAOS_CLK_NS)
`define SAOS_WD_POST_LAST    8'h03

// ==========================================================
// Register offsets
`define SAOS_REG_CTRL        4'h0
`define SAOS_REG_FLAGS       4'h1
`define SAOS_REG_WREG        4'h2
`define SAOS_REG_BANKSEL     4'h3
`define SAOS_REG_WDCNT       4'h4
`define SAOS_REG_IRQ_STAT    4'h5
`define SAOS_REG_IRQ_MASK    4'h6
`define SAOS_REG_WDPOST      4'h7

// ==========================================================
// Field positions
`define SAOS_CTRL_RUN        0
`define SAOS_CTRL_WD_EN      1
`define SAOS_FLG_PWRDN       0
`define SAOS_FLG_TMOUT       1
`define SAOS_FLG_SLEEP       2
`define SAOS_FLG_NEG         3
`define SAOS_FLG_ZERO        4
`define SAOS_IRQ_SLEEP       0
`define SAOS_IRQ_WAKE_WD     1
`define SAOS_IRQ_WAKE_EXT    2
`define SAOS_IRQ_WD_AWAKE    3

// ==========================================================
// Reset values
`define SAOS_CTRL_RST        8'h01
`define SAOS_PWRDN_RST       1'b1
`define SAOS_TMOUT_RST       1'b1
`define SAOS_IRQ_MASK_RST    8'h00

// ==========================================================
// Encodings and constants
`define SAOS_OP_SET_ONES     7'h34
`define SAOS_OP_ROT_NC       6'h10
`define SAOS_OP_SLEEP        16'h0003
`define SAOS_ALL_ONES        8'hff
`define SAOS_WDT_CLR         8'h00
`define SAOS_ACC_SPLIT       8'h80
`define SAOS_ACC_LO_BANK     4'h0
`define SAOS_ACC_HI_BANK     4'hf

`endif

//--- core/saos_qgen.v
`timescale 1ns/1ns
`default_nettype none
`include "saos_defs.vh"

module saos_qgen (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       osc_run,
  output wire       q_tick,
  output reg  [3:0] q_phase_r
);

  localparam integer Q_LAST_I = `SAOS_Q_CYC - 1;
  localparam [7:0]   Q_LAST   = Q_LAST_I[7:0];

  reg [7:0] div_r;

  // ==========================================================
  // Phase divider, held at Q1 while the oscillator is halted
  assign q_tick = osc_run & (div_r == Q_LAST);

  always @(posedge clk_sys) begin
    if (sys_rst || !osc_run) begin
      div_r     <= 8'h00;
      q_phase_r <= 4'h1;
    end else if (q_tick) begin
      div_r     <= 8'h00;
      q_phase_r <= {q_phase_r[2:0], q_phase_r[3]};
    end else begin
      div_r     <= div_r + 8'h01;
    end
  end

endmodule // saos_qgen

`default_nettype wire

//--- dv/saos_exec_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "saos_defs.vh"

module saos_exec_asserts (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [15:0] instr_word,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [7:0]  mem_rdata,
  input wire logic [11:0] mem_waddr_r,
  input wire logic [7:0]  mem_wdata_r,
  input wire logic        mem_we_r,
  input wire logic        osc_run,
  input wire logic        sleeping,
  input wire logic        timeout_flag,
  input wire logic        powerdown_flag,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr
);
  // ====
  // Shadows of the taken word and the bank select
  logic [15:0] iw_r;
  logic [3:0]  bsr_r;
  logic        is_rot;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      iw_r  <= 16'h0000;
      bsr_r <= 4'h0;
    end else begin
      if (instr_valid && instr_ready)
        iw_r <= instr_word;
      if (reg_wr && reg_addr == `SAOS_REG_BANKSEL)
        bsr_r <= reg_wdata[3:0];
    end
  end
  assign is_rot = iw_r[15:10] == `SAOS_OP_ROT_NC;

  // ====
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    instr_valid && instr_ready;
  endsequence
  sequence s_ones;
    s_take ##0 instr_word[15:9] == `SAOS_OP_SET_ONES;
  endsequence
  sequence s_sleep;
    s_take ##0 instr_word == `SAOS_OP_SLEEP;
  endsequence

  a_ones_written: assert property (
    s_ones |-> ##[12:14] (mem_we_r && mem_wdata_r == `SAOS_ALL_ONES))
    else $error("set-all-ones wrote no FFh");
  a_bank_access: assert property (
    mem_we_r && !iw_r[8] |-> mem_waddr_r ==
    {iw_r[7] ? `SAOS_ACC_HI_BANK : `SAOS_ACC_LO_BANK, iw_r[7:0]})
    else $error("access bank address wrong");
  a_bank_select: assert property (
    mem_we_r && iw_r[8] |-> mem_waddr_r == {bsr_r, iw_r[7:0]})
    else $error("banked address wrong");
  a_ones_single: assert property (
    s_ones |-> ##16 instr_ready)
    else $error("set-all-ones not one cycle");
  a_sleep_flags: assert property (
    s_sleep |-> ##[12:14] (!powerdown_flag && timeout_flag))
    else $error("sleep flags wrong");
  a_sleep_osc: assert property (
    s_sleep |-> ##[12:14] (sleeping && !osc_run))
    else $error("sleep did not halt oscillator");
  a_rot_right: assert property (
    mem_we_r && is_rot |-> mem_wdata_r == {mem_rdata[0], mem_rdata[7:1]})
    else $error("rotate result wrong");
  a_rot_dest: assert property (
    mem_we_r |-> !(is_rot && !iw_r[9]))
    else $error("rotate to W wrote memory");
  a_wake_to_clr: assert property (
    $fell(timeout_flag) |-> ($fell(sleeping) && !powerdown_flag))
    else $error("timeout flag cleared outside a wake");
endmodule // saos_exec_asserts

bind saos_exec saos_exec_asserts i_saos_exec_asserts (
  .clk_sys, .sys_rst, .instr_word, .instr_valid, .instr_ready, .mem_rdata,
  .mem_waddr_r, .mem_wdata_r, .mem_we_r, .osc_run, .sleeping, .timeout_flag,
  .powerdown_flag, .reg_addr, .reg_wdata, .reg_wr
);
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "saos_defs.vh"

module tb_top;
  // ====
  // Design ports and bench state
  logic        clk_sys, sys_rst, instr_valid, wake_pin, reg_wr, reg_rd;
  logic [15:0] instr_word;
  logic [7:0]  mem_rdata, reg_wdata;
  logic [3:0]  reg_addr;
  wire         instr_ready, mem_we_r, osc_run, sleeping, irq;
  wire         timeout_flag, powerdown_flag;
  wire  [11:0] mem_raddr_r, mem_waddr_r;
  wire  [7:0]  mem_wdata_r, reg_rdata_r;
  logic [7:0]  mem [0:4095];
  int          mdl [0:4095];
  int          errors, samples_checked, bank_m, w_m, nf, zf;
  integer      seed;

  saos_exec i_saos_exec (
    .clk_sys, .sys_rst, .instr_word, .instr_valid, .instr_ready,
    .mem_raddr_r, .mem_rdata, .mem_waddr_r, .mem_wdata_r, .mem_we_r,
    .wake_pin, .osc_run, .sleeping, .timeout_flag, .powerdown_flag,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .irq
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Data memory answers one cycle after the read address
  always @(posedge clk_sys) begin
    mem_rdata <= mem[mem_raddr_r];
    if (mem_we_r === 1'b1)
      mem[mem_waddr_r] <= mem_wdata_r;
  end

  // ====
  // Tasks
  task automatic chk(input string n, input int e, input logic [7:0] s);
    samples_checked++;
    if (s !== e[7:0]) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e[7:0], s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input int e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata_r", e, reg_rdata_r);
  endtask
  task automatic exec(input logic [15:0] w);
    int i;
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    for (i = 0; i < 40; i++) begin
      #1;
      if (instr_ready === 1'b1) break;
      @(posedge clk_sys);
    end
    if (i == 40) errors++;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    repeat (15) @(posedge clk_sys);
    #1;
  endtask
  task automatic print_verdict();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic int ea(int f, int a);
    if (a != 0) return bank_m * 256 + f;
    return (f >= 8'h80) ? 12'hf00 + f : f;
  endfunction

  initial begin
    #400000;
    errors++;
    print_verdict();
  end

  // ====
  // Main sequence
  initial begin
    int k, f, a, d, e, v, r;
    seed = 71817;
    {errors, samples_checked, w_m, nf, zf} = 0;
    {sys_rst, instr_valid, wake_pin, reg_wr, reg_rd} = 5'h10;
    {instr_word, mem_rdata, reg_wdata, reg_addr} = 0;
    for (k = 0; k < 4096; k++) begin
      mem[k] = $random(seed) & 8'hfe;
      mdl[k] = mem[k];
    end
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`SAOS_REG_FLAGS, 3);
    rd(`SAOS_REG_CTRL, `SAOS_CTRL_RST);
    rd(4'h9, 0);
    bank_m = ($random(seed) & 7) + 4;
    wr(`SAOS_REG_BANKSEL, bank_m[7:0]);
    for (k = 0; k < 16; k++) begin
      f = $random(seed) & 255;
      a = k & 1;
      d = (k >> 2) & 1;
      e = ea(f, a);
      if (k & 2) begin
        v = mdl[e];
        r = ((v >> 1) | (v << 7)) & 255;
        nf = r >> 7;
        zf = r == 0;
        exec({`SAOS_OP_ROT_NC, d[0], a[0], f[7:0]});
        if (d != 0) mdl[e] = r;
        else w_m = r;
      end else begin
        mdl[e] = 255;
        exec({`SAOS_OP_SET_ONES, a[0], f[7:0]});
      end
      chk("data memory", mdl[e], mem[e]);
      rd(`SAOS_REG_WREG, w_m);
      rd(`SAOS_REG_FLAGS, 3 | zf << 4 | nf << 3);
    end
    wr(`SAOS_REG_CTRL, 8'h03);
    repeat (64600) @(posedge clk_sys);
    rd(`SAOS_REG_WDPOST, 1);
    wr(`SAOS_REG_IRQ_MASK, 8'h0f);
    exec(`SAOS_OP_SLEEP);
    chk("sleeping", 1, {7'h00, sleeping});
    chk("osc_run", 0, {7'h00, osc_run});
    rd(`SAOS_REG_FLAGS, 6 | zf << 4 | nf << 3);
    rd(`SAOS_REG_WDCNT, 0);
    rd(`SAOS_REG_WDPOST, 0);
    chk("irq", 1, {7'h00, irq});
    wr(`SAOS_REG_IRQ_MASK, 8'h00);
    #1;
    chk("irq", 0, {7'h00, irq});
    @(posedge clk_sys);
    wake_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    wake_pin <= 1'b0;
    #1;
    chk("sleeping", 0, {7'h00, sleeping});
    rd(`SAOS_REG_FLAGS, 2 | zf << 4 | nf << 3);
    rd(`SAOS_REG_IRQ_STAT, 8'h05);
    wr(`SAOS_REG_IRQ_STAT, 8'h05);
    rd(`SAOS_REG_IRQ_STAT, 0);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
